// ---- src/ast_regs.svh ----
// Purpose: Register map, field positions, reset values and timing counts of the
//          asynchronous serial transceiver.
// Assumes: 32-bit AHB-Lite words, one register per aligned word.
// Notes:   Flags in the status word are cleared by writing 0 to them, the end flag by writing 0 to the empty flag.
// Contract
// (RULE1) Idle line high; low level starts character
// (RULE2) Start, data LSB first, parity, stops
// (RULE3) Sample each bit on 8th 16x pulse
// (RULE4) Twelve formats: length, parity, stops, multiprocessor
// (RULE5) External clock runs at sixteen times bitrate
// (RULE6) Clock out rises at every bit centre
// (RULE7) Source pair: internal, internal+out, external, reserved
// (RULE8) Software disables both directions before reconfiguring
// (RULE9) Transmit disable sets buffer-empty flag
// (RULE10) Receive disable keeps flags and received data
// (RULE11) External clock never stops during operation
// (RULE12) Empty flag low: load shifter, set flag
// (RULE13) Pending data starts next frame after stop
// (RULE14) Nothing pending: set end flag, hold high
// (RULE15) Receiver shifts data LSB first, then parity/stop
// (RULE16) Parity checked against odd/even select
// (RULE17) Only first stop bit is checked
// (RULE18) Clean character stored, full flag set
// (RULE19) Errors set own flag, full flag kept
// (RULE20) Overrun when full flag still set; discard
// (RULE21) Stop bit low: framing error, data kept
// (RULE22) Parity mismatch: parity error, data discarded
// (RULE23) No reception while any error flag set
// (RULE24) Baud generator makes the 16x tick
`ifndef AST_REGS_SVH
`define AST_REGS_SVH
`define AST_OFS_MODE       8'h00
`define AST_OFS_CTRL       8'h04
`define AST_OFS_STATUS     8'h08
`define AST_OFS_TXDATA     8'h0C
`define AST_OFS_RXDATA     8'h10
`define AST_OFS_BAUD       8'h14
`define AST_MODE_MULTI     2
`define AST_MODE_STOP2     3
`define AST_MODE_ODD       4
`define AST_MODE_PAR_EN    5
`define AST_MODE_CHAR7     6
`define AST_CTRL_CKSEL_LO  0
`define AST_CTRL_CKSEL_HI  1
`define AST_CTRL_TXEND_IE  2
`define AST_CTRL_RX_EN     4
`define AST_CTRL_TX_EN     5
`define AST_CTRL_RX_IE     6
`define AST_CTRL_TX_IE     7
`define AST_ST_MBIT_TX     0
`define AST_ST_MBIT_RX     1
`define AST_ST_TX_END      2
`define AST_ST_PAR_ERR     3
`define AST_ST_FRM_ERR     4
`define AST_ST_OVR         5
`define AST_ST_RX_FULL     6
`define AST_ST_TX_EMPTY    7
`define AST_MODE_RST       8'h00
`define AST_CTRL_RST       8'h00
`define AST_BAUD_RST       16'h0035
`define AST_SAMPLE_PH      4'h7
`define AST_LAST_PH        4'hF
`endif

// ---- src/ast_pkg.sv ----
// Purpose: Types shared by both ends of the serial link.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Constants live in ast_regs.svh.
package ast_pkg;
  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_PAR   = 3'b011,
    RX_STOP  = 3'b100
  } ast_rx_state_type;
  typedef enum logic [1:0] {
    CK_INT     = 2'b00,
    CK_INT_OUT = 2'b01,
    CK_EXT     = 2'b10,
    CK_RSVD    = 2'b11
  } ast_clk_src_type;
endpackage

// ---- src/ast_link_if.sv ----
// Purpose: Serial link between the transceiver and the remote node.
// Assumes: Shared clock pin idles high when nobody drives it.
// Notes:   Data lines are one-way; the clock pin is resolved here.
`timescale 1ns/1ns
`default_nettype none
interface ast_link_if;
  logic line_d2r;
  logic line_r2d;
  logic sck_dev_o;
  logic sck_dev_oe;
  logic sck_rem_o;
  logic sck_rem_oe;
  logic sck;
  assign sck = sck_dev_oe ? sck_dev_o : (sck_rem_oe ? sck_rem_o : 1'b1);
  modport dev (output line_d2r, sck_dev_o, sck_dev_oe, input line_r2d, sck);
  modport rem (output line_r2d, sck_rem_o, sck_rem_oe, input line_d2r, sck);
endinterface
`default_nettype wire

// ---- src/ast_remote.sv ----
// Purpose: Remote asynchronous node: one frame format, optional 16x clock source.
// Assumes: Format inputs agree with the transceiver's mode register.
// Notes:   Bit timing comes from its own divider, also driven out when asked.
`timescale 1ns/1ns
`default_nettype none
`include "ast_regs.svh"
module ast_remote #(
  parameter int unsigned DIV16 = 54
) (
  // Clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  // Frame format and clock output
  input  wire logic       i_char7,
  input  wire logic       i_parity_en,
  input  wire logic       i_parity_odd,
  input  wire logic       i_two_stop,
  input  wire logic       i_multiproc,
  input  wire logic       i_mp_bit,
  input  wire logic       i_clk_out_en,
  // Transmit side
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_tx_ready,
  // Receive side
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  output logic            o_rx_perr,
  output logic            o_rx_ferr,
  // Serial link
  ast_link_if.rem         link
);
  logic [15:0] dcnt_q;
  logic [3:0]  ph_q;
  logic        sck_q;
  logic        tick;
  logic        bit_end;
  logic        busy_q;
  logic [11:0] frame_q;
  logic [3:0]  left_q;
  logic        txd_q;
  logic [7:0]  d;
  logic        pbit;
  logic [3:0]  len;
  logic        r1_q, r2_q;
  ast_pkg::ast_rx_state_type rst_q;
  logic [3:0]  rcnt_q;
  logic [2:0]  rn_q;
  logic [7:0]  rsh_q;
  logic        rpar_q;
  logic        samp;

  assign tick    = (dcnt_q == 16'(DIV16 - 1));
  assign bit_end = tick && (ph_q == `AST_LAST_PH);

  // Free-running divider keeps the pin toggling even between frames [RULE11]
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      dcnt_q <= 16'h0000;
      ph_q   <= 4'h0;
      sck_q  <= 1'b0;
    end else begin
      dcnt_q <= tick ? 16'h0000 : dcnt_q + 16'h0001;
      sck_q  <= (dcnt_q < 16'(DIV16 / 2)); // [RULE5]
      if (tick) begin
        ph_q <= ph_q + 4'h1;
      end
    end
  end
  assign link.sck_rem_o  = sck_q;
  assign link.sck_rem_oe = i_clk_out_en; // [RULE5]

  assign d    = i_char7 ? {1'b0, i_tx_data[6:0]} : i_tx_data;
  assign pbit = i_multiproc ? i_mp_bit : (i_parity_en ? (^d ^ i_parity_odd) : 1'b1);
  assign len  = 4'h1 + (i_char7 ? 4'h7 : 4'h8) + {3'h0, i_multiproc | i_parity_en}
              + (i_two_stop ? 4'h2 : 4'h1);
  assign o_tx_ready = !busy_q;

  // Whole frame shifts out LSB first; idle and stop are ones [RULE1] [RULE2]
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      busy_q  <= 1'b0;
      frame_q <= 12'hFFF;
      left_q  <= 4'h0;
      txd_q   <= 1'b1;
    end else if (i_tx_valid && !busy_q) begin
      busy_q  <= 1'b1;
      frame_q <= i_char7 ? {4'hF, pbit, d[6:0]} : {3'h7, pbit, d};
      left_q  <= len + 4'h1;
    end else if (bit_end && busy_q) begin
      if (left_q == 4'h1) begin
        busy_q <= 1'b0;
        txd_q  <= 1'b1;
      end else if (left_q == len + 4'h1) begin
        txd_q  <= 1'b0;
        left_q <= left_q - 4'h1;
      end else begin
        txd_q   <= frame_q[0];
        frame_q <= {1'b1, frame_q[11:1]};
        left_q  <= left_q - 4'h1;
      end
    end
  end
  assign link.line_r2d = txd_q;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      r1_q <= 1'b1;
      r2_q <= 1'b1;
    end else begin
      r1_q <= link.line_d2r;
      r2_q <= r1_q;
    end
  end

  assign samp = tick && (((rst_q == ast_pkg::RX_START) && (rcnt_q == `AST_SAMPLE_PH))
              || ((rst_q != ast_pkg::RX_START) && (rcnt_q == `AST_LAST_PH)));

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rst_q      <= ast_pkg::RX_IDLE;
      rcnt_q     <= 4'h0;
      rn_q       <= 3'h0;
      rsh_q      <= 8'h00;
      rpar_q     <= 1'b0;
      o_rx_valid <= 1'b0;
      o_rx_data  <= 8'h00;
      o_rx_perr  <= 1'b0;
      o_rx_ferr  <= 1'b0;
    end else begin
      o_rx_valid <= 1'b0;
      if (tick) begin
        rcnt_q <= (samp && rst_q == ast_pkg::RX_START) ? 4'h0 : rcnt_q + 4'h1;
      end
      case (rst_q)
        ast_pkg::RX_IDLE: begin
          if (!r2_q) begin
            rst_q  <= ast_pkg::RX_START;
            rcnt_q <= 4'h0;
          end
        end
        ast_pkg::RX_START: begin
          if (samp) begin
            rst_q <= r2_q ? ast_pkg::RX_IDLE : ast_pkg::RX_DATA;
            rn_q  <= 3'h0;
          end
        end
        ast_pkg::RX_DATA: begin
          if (samp) begin
            rsh_q <= {r2_q, rsh_q[7:1]};
            rn_q  <= rn_q + 3'h1;
            if (rn_q == (i_char7 ? 3'h6 : 3'h7)) begin
              rst_q <= (i_parity_en || i_multiproc) ? ast_pkg::RX_PAR : ast_pkg::RX_STOP;
            end
          end
        end
        ast_pkg::RX_PAR: begin
          if (samp) begin
            rpar_q <= r2_q;
            rst_q  <= ast_pkg::RX_STOP;
          end
        end
        default: begin
          if (samp) begin
            rst_q      <= ast_pkg::RX_IDLE;
            o_rx_valid <= 1'b1;
            o_rx_data  <= i_char7 ? {1'b0, rsh_q[7:1]} : rsh_q;
            o_rx_ferr  <= !r2_q;
            o_rx_perr  <= i_parity_en && !i_multiproc
                        && ((^(i_char7 ? {1'b0, rsh_q[7:1]} : rsh_q)) ^ rpar_q ^ i_parity_odd);
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- src/ast_dev.sv ----
// Purpose: Asynchronous serial transceiver with an AHB-Lite register file.
// Assumes: Single word transfers only; the slave never inserts wait states.
// Notes:   Software clears status flags by writing 0, the end flag through the empty flag; writing 1 leaves them.
`timescale 1ns/1ns
`default_nettype none
`include "ast_regs.svh"
module ast_dev (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  // Event requests
  output logic             o_tx_irq,
  output logic             o_tx_end_irq,
  output logic             o_rx_irq,
  output logic             o_rx_error_irq,
  // Serial link
  ast_link_if.dev          link
);
  logic        act_q, wr_q;
  logic [7:0]  addr_q;
  logic        w_mode, w_ctrl, w_stat, w_tdr, w_baud;
  logic [7:0]  mode_q, ctrl_q, tdr_q, rxb_q, stat;
  logic [15:0] baud_q, bcnt_q;
  logic        txe_q, tfin_q, rxf_q, ovr_q, fer_q, per_q, mbit_rx_q, mbit_tx_q;
  logic        c7, pen, odd, two, mpf, txon, rxon;
  ast_pkg::ast_clk_src_type cks;
  logic        k1_q, k2_q, k3_q, tick;
  logic [3:0]  ph_q;
  logic        bit_end, sck_q;
  logic        busy_q, txd_q, tx_load, tx_done;
  logic [11:0] frame_q;
  logic [3:0]  left_q, len;
  logic [7:0]  td;
  logic        pbit;
  logic        r1_q, r2_q, samp, rx_done, par_bad, err_any;
  ast_pkg::ast_rx_state_type rst_q;
  logic [3:0]  rcnt_q;
  logic [2:0]  rn_q;
  logic [7:0]  rsh_q, rdata;
  logic        rpar_q;

  assign c7  = mode_q[`AST_MODE_CHAR7];
  assign pen = mode_q[`AST_MODE_PAR_EN];
  assign odd = mode_q[`AST_MODE_ODD];
  assign two = mode_q[`AST_MODE_STOP2];
  assign mpf = mode_q[`AST_MODE_MULTI];
  assign txon = ctrl_q[`AST_CTRL_TX_EN];
  assign rxon = ctrl_q[`AST_CTRL_RX_EN];
  assign cks = ast_pkg::ast_clk_src_type'({ctrl_q[`AST_CTRL_CKSEL_HI], ctrl_q[`AST_CTRL_CKSEL_LO]});

  // Bus: address phase captured, write applied in the data phase
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      act_q  <= 1'b0;
      wr_q   <= 1'b0;
      addr_q <= 8'h00;
    end else if (i_hready) begin
      act_q  <= i_hsel && i_htrans[1];
      wr_q   <= i_hwrite;
      addr_q <= i_haddr[7:0];
    end
  end
  assign w_mode = act_q && wr_q && (addr_q == `AST_OFS_MODE);
  assign w_ctrl = act_q && wr_q && (addr_q == `AST_OFS_CTRL);
  assign w_stat = act_q && wr_q && (addr_q == `AST_OFS_STATUS);
  assign w_tdr  = act_q && wr_q && (addr_q == `AST_OFS_TXDATA);
  assign w_baud = act_q && wr_q && (addr_q == `AST_OFS_BAUD);
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  assign stat = {txe_q, rxf_q, ovr_q, fer_q, per_q, tfin_q, mbit_rx_q, mbit_tx_q};
  always_comb begin
    o_hrdata = 32'h0000_0000;
    if (addr_q == `AST_OFS_MODE) begin
      o_hrdata[7:0] = mode_q;
    end else if (addr_q == `AST_OFS_CTRL) begin
      o_hrdata[7:0] = ctrl_q;
    end else if (addr_q == `AST_OFS_STATUS) begin
      o_hrdata[7:0] = stat;
    end else if (addr_q == `AST_OFS_TXDATA) begin
      o_hrdata[7:0] = tdr_q;
    end else if (addr_q == `AST_OFS_RXDATA) begin
      o_hrdata[7:0] = rxb_q;
    end else if (addr_q == `AST_OFS_BAUD) begin
      o_hrdata[15:0] = baud_q;
    end
  end

  // Settings are taken as written; software quiesces both directions first [RULE8]
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      mode_q   <= `AST_MODE_RST;
      ctrl_q   <= `AST_CTRL_RST;
      tdr_q    <= 8'h00;
      baud_q   <= `AST_BAUD_RST;
      mbit_tx_q <= 1'b0;
    end else begin
      if (w_mode) mode_q <= i_hwdata[7:0];
      if (w_ctrl) ctrl_q <= i_hwdata[7:0];
      if (w_tdr) tdr_q <= i_hwdata[7:0];
      if (w_baud) baud_q <= i_hwdata[15:0];
      if (w_stat) mbit_tx_q <= i_hwdata[`AST_ST_MBIT_TX];
    end
  end

  // 16x tick from the baud counter or from the synchronised clock pin [RULE24] [RULE7]
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      bcnt_q <= 16'h0000;
      k1_q   <= 1'b0;
      k2_q   <= 1'b0;
      k3_q   <= 1'b0;
    end else begin
      bcnt_q <= (bcnt_q >= baud_q) ? 16'h0000 : bcnt_q + 16'h0001;
      k1_q   <= link.sck;
      k2_q   <= k1_q;
      k3_q   <= k2_q;
    end
  end
  always_comb begin
    tick = 1'b0;
    case (cks)
      ast_pkg::CK_INT, ast_pkg::CK_INT_OUT: tick = (bcnt_q == baud_q);
      ast_pkg::CK_EXT: tick = k2_q && !k3_q; // [RULE5]
      default: tick = 1'b0;
    endcase
  end

  // Bit phase runs freely so the clock output keeps its place between frames
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ph_q  <= 4'h0;
      sck_q <= 1'b0;
    end else begin
      if (tick) ph_q <= ph_q + 4'h1;
      sck_q <= ph_q[3]; // Rises at phase 8, the centre of a bit [RULE6]
    end
  end
  assign bit_end         = tick && (ph_q == `AST_LAST_PH);
  assign link.sck_dev_o  = sck_q;
  assign link.sck_dev_oe = (cks == ast_pkg::CK_INT_OUT); // [RULE7]

  // Frame image: data, parity or multiprocessor bit, then ones for stop [RULE4] [RULE2]
  assign td   = c7 ? {1'b0, tdr_q[6:0]} : tdr_q;
  assign pbit = mpf ? mbit_tx_q : (pen ? (^td ^ odd) : 1'b1);
  assign len  = 4'h1 + (c7 ? 4'h7 : 4'h8) + {3'h0, pen | mpf} + (two ? 4'h2 : 4'h1);
  // Next character is checked while the last stop bit is on the line [RULE13] [RULE14]
  assign tx_load = txon && bit_end && !txe_q && (!busy_q || left_q == 4'h1); // [RULE12]
  assign tx_done = txon && bit_end && busy_q && (left_q == 4'h1) && txe_q;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      busy_q  <= 1'b0;
      frame_q <= 12'hFFF;
      left_q  <= 4'h0;
      txd_q   <= 1'b1;
    end else if (!txon) begin
      busy_q <= 1'b0;
      txd_q  <= 1'b1;
    end else if (tx_load) begin
      busy_q  <= 1'b1;
      txd_q   <= 1'b0; // [RULE2]
      frame_q <= c7 ? {4'hF, pbit, td[6:0]} : {3'h7, pbit, td};
      left_q  <= len;
    end else if (tx_done) begin
      busy_q <= 1'b0;
      txd_q  <= 1'b1; // [RULE14] [RULE1]
    end else if (bit_end && busy_q) begin
      txd_q   <= frame_q[0];
      frame_q <= {1'b1, frame_q[11:1]};
      left_q  <= left_q - 4'h1;
    end
  end
  assign link.line_d2r = txd_q;

  // Sets come after the software clear so an event in that cycle is kept
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      txe_q  <= 1'b1;
      tfin_q <= 1'b1;
    end else begin
      if (w_stat && !i_hwdata[`AST_ST_TX_EMPTY]) begin
        txe_q  <= 1'b0;
        tfin_q <= 1'b0;
      end
      if (tx_load) txe_q <= 1'b1; // [RULE12]
      if (tx_done) tfin_q <= 1'b1; // [RULE14]
      if (!txon) txe_q <= 1'b1; // [RULE9]
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      r1_q <= 1'b1;
      r2_q <= 1'b1;
    end else begin
      r1_q <= link.line_r2d;
      r2_q <= r1_q;
    end
  end

  assign err_any = ovr_q || fer_q || per_q;
  // Start centre on the 8th tick, every later bit 16 ticks on [RULE3]
  assign samp = tick && (((rst_q == ast_pkg::RX_START) && (rcnt_q == `AST_SAMPLE_PH))
              || ((rst_q != ast_pkg::RX_START) && (rcnt_q == `AST_LAST_PH)));
  assign rx_done = rxon && samp && (rst_q == ast_pkg::RX_STOP);
  assign rdata   = c7 ? {1'b0, rsh_q[7:1]} : rsh_q;
  assign par_bad = pen && !mpf && (^rdata ^ rpar_q ^ odd); // [RULE16]

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rst_q  <= ast_pkg::RX_IDLE;
      rcnt_q <= 4'h0;
      rn_q   <= 3'h0;
      rsh_q  <= 8'h00;
      rpar_q <= 1'b0;
    end else if (!rxon) begin
      rst_q <= ast_pkg::RX_IDLE; // Only the sequencer stops [RULE10]
    end else begin
      if (tick) begin
        rcnt_q <= (samp && rst_q == ast_pkg::RX_START) ? 4'h0 : rcnt_q + 4'h1;
      end
      case (rst_q)
        ast_pkg::RX_IDLE: begin
          if (!r2_q && !err_any) begin // [RULE1] [RULE23]
            rst_q  <= ast_pkg::RX_START;
            rcnt_q <= 4'h0;
          end
        end
        ast_pkg::RX_START: begin
          if (samp) begin
            rst_q <= r2_q ? ast_pkg::RX_IDLE : ast_pkg::RX_DATA; // Glitch rejected
            rn_q  <= 3'h0;
          end
        end
        ast_pkg::RX_DATA: begin
          if (samp) begin
            rsh_q <= {r2_q, rsh_q[7:1]}; // [RULE15]
            rn_q  <= rn_q + 3'h1;
            if (rn_q == (c7 ? 3'h6 : 3'h7)) begin
              rst_q <= (pen || mpf) ? ast_pkg::RX_PAR : ast_pkg::RX_STOP; // [RULE4]
            end
          end
        end
        ast_pkg::RX_PAR: begin
          if (samp) begin
            rpar_q <= r2_q;
            rst_q  <= ast_pkg::RX_STOP;
          end
        end
        default: begin
          if (samp) rst_q <= ast_pkg::RX_IDLE; // Second stop reads as idle [RULE17]
        end
      endcase
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rxf_q     <= 1'b0;
      ovr_q     <= 1'b0;
      fer_q     <= 1'b0;
      per_q     <= 1'b0;
      rxb_q     <= 8'h00;
      mbit_rx_q <= 1'b0;
    end else begin
      if (w_stat) begin
        if (!i_hwdata[`AST_ST_RX_FULL]) rxf_q <= 1'b0;
        if (!i_hwdata[`AST_ST_OVR]) ovr_q <= 1'b0;
        if (!i_hwdata[`AST_ST_FRM_ERR]) fer_q <= 1'b0;
        if (!i_hwdata[`AST_ST_PAR_ERR]) per_q <= 1'b0;
      end
      if (rx_done) begin
        if (rxf_q) begin
          ovr_q <= 1'b1; // [RULE20] [RULE19]
        end else begin
          if (par_bad) per_q <= 1'b1; // [RULE22]
          if (!r2_q) fer_q <= 1'b1; // [RULE21] [RULE17]
          if (!par_bad) begin
            rxb_q     <= rdata; // [RULE21] [RULE18]
            mbit_rx_q <= mpf && rpar_q;
          end
          if (!par_bad && r2_q) rxf_q <= 1'b1; // [RULE18] [RULE19]
        end
      end
    end
  end

  assign o_tx_irq       = ctrl_q[`AST_CTRL_TX_IE] && txe_q; // [RULE12]
  assign o_tx_end_irq   = ctrl_q[`AST_CTRL_TXEND_IE] && tfin_q; // [RULE14]
  assign o_rx_irq       = ctrl_q[`AST_CTRL_RX_IE] && rxf_q; // [RULE18]
  assign o_rx_error_irq = ctrl_q[`AST_CTRL_RX_IE] && err_any; // [RULE19]
endmodule
`default_nettype wire

// ---- bench/ast_link_chk.sv ----
// Purpose: Assertions on the serial link between the two ends.
// Assumes: Both ends use BIT clocks per bit; no frame is aborted.
// Notes:   Clock pin phase gets two clocks of slack for the tick pipeline.
`timescale 1ns/1ns
`default_nettype none
module ast_link_chk #(
  parameter int BIT = 64
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Link
  input wire logic line_d2r,
  input wire logic line_r2d,
  input wire logic sck_dev_o,
  input wire logic sck_dev_oe
);
  logic ld_q;
  logic lr_q;
  logic ck_q;
  logic ck_ok_q;
  int   rd_q;
  int   rr_q;
  int   ck_n_q;
  // Run lengths count the cycles the previous level was held
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      ld_q    <= 1'b1;
      lr_q    <= 1'b1;
      ck_q    <= 1'b0;
      ck_ok_q <= 1'b0;
      rd_q    <= 0;
      rr_q    <= 0;
      ck_n_q  <= 0;
    end else begin
      ld_q    <= line_d2r;
      lr_q    <= line_r2d;
      ck_q    <= sck_dev_o;
      ck_ok_q <= sck_dev_oe && (ck_ok_q || (sck_dev_o && !ck_q));
      rd_q    <= (line_d2r != ld_q) ? 1 : rd_q + 1;
      rr_q    <= (line_r2d != lr_q) ? 1 : rr_q + 1;
      ck_n_q  <= (sck_dev_o && !ck_q) ? 1 : ck_n_q + 1;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  sequence s_d_up; line_d2r && !ld_q; endsequence
  sequence s_d_dn; !line_d2r && ld_q; endsequence
  sequence s_r_up; line_r2d && !lr_q; endsequence
  sequence s_r_dn; !line_r2d && lr_q; endsequence
  // First rise after the output is enabled has no reference, so it is skipped
  sequence s_ck_up; sck_dev_o && !ck_q && ck_ok_q; endsequence
  property p_idle; $rose(i_rst_n) |-> line_d2r && line_r2d; endproperty
  property p_d_grid; s_d_up |-> rd_q % BIT == 0; endproperty
  property p_d_max; s_d_up |-> rd_q <= 10 * BIT; endproperty
  property p_d_stop; s_d_dn |-> rd_q >= BIT; endproperty
  property p_r_grid; s_r_up |-> rr_q % BIT == 0; endproperty
  property p_r_max; s_r_up |-> rr_q <= 10 * BIT; endproperty
  property p_r_stop; s_r_dn |-> rr_q >= BIT; endproperty
  property p_ck_per; s_ck_up |-> ck_n_q == BIT; endproperty
  property p_ck_mid; $changed(line_d2r) && ck_ok_q |-> ck_n_q inside {[BIT/2-2:BIT/2+2]}; endproperty
  a_idle: assert property (p_idle) else $error("line low after reset");
  a_d_grid: assert property (p_d_grid) else $error("device low run off grid");
  a_d_max: assert property (p_d_max) else $error("device low run too long");
  a_d_stop: assert property (p_d_stop) else $error("device stop too short");
  a_r_grid: assert property (p_r_grid) else $error("remote low run off grid");
  a_r_max: assert property (p_r_max) else $error("remote low run too long");
  a_r_stop: assert property (p_r_stop) else $error("remote stop too short");
  a_ck_per: assert property (p_ck_per) else $error("clock out period wrong");
  a_ck_mid: assert property (p_ck_mid) else $error("clock out not centred");
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
// Purpose: Self-checking bench: transceiver and remote node face each other.
// Assumes: Baud 3 and DIV16 4 give both ends 64 clocks per bit.
// Notes:   The external 16x clock comes from the remote at the same rate.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic             i_clock = 1'b0;
  logic             i_rst_n = 1'b0;
  logic [7:0]       haddr = 8'h0;
  logic [31:0]      hwdata = 32'h0;
  logic [1:0]       htrans = 2'h0;
  logic             hwrite = 1'b0;
  logic [5:0]       fmt = 6'h0;
  logic [5:0]       f;
  logic             tv = 1'b0;
  logic             ko = 1'b0;
  int               wn = 0;
  logic [7:0]       td = 8'h0;
  logic [31:0]      seed = 32'h2;
  logic [31:0]      v;
  logic [31:0]      r;
  int               err_total = 0;
  int               tests_run = 0;
  wire logic        hready;
  wire logic [31:0] hrdata;
  wire logic [7:0]  rdat;
  wire logic [1:0]  rerr;
  wire logic [5:0]  ev;
  ast_link_if link ();
  ast_dev u_ast_dev (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_hsel(1'b1),
    .i_haddr({24'h0, haddr}), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready), .o_hresp(),
    .o_hrdata(hrdata), .o_tx_irq(ev[4]), .o_tx_end_irq(ev[3]), .o_rx_irq(ev[2]),
    .o_rx_error_irq(ev[1]), .link(link));
  ast_remote #(.DIV16(4)) u_ast_remote (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_char7(fmt[5]), .i_parity_en(fmt[4]), .i_parity_odd(fmt[3]), .i_two_stop(fmt[2]),
    .i_multiproc(fmt[1]), .i_mp_bit(fmt[0]), .i_clk_out_en(ko), .i_tx_valid(tv),
    .i_tx_data(td), .o_tx_ready(ev[5]), .o_rx_valid(ev[0]), .o_rx_data(rdat),
    .o_rx_perr(rerr[1]), .o_rx_ferr(rerr[0]), .link(link));
  ast_link_chk #(.BIT(64)) u_ast_link_chk (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .line_d2r(link.line_d2r), .line_r2d(link.line_r2d), .sck_dev_o(link.sck_dev_o),
    .sck_dev_oe(link.sck_dev_oe));
  always #5 i_clock = ~i_clock;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // 7-bit characters arrive in the low bits
  function automatic logic [31:0] ch7(input logic [7:0] x, input logic [5:0] g);
    return {24'h0, g[5] ? {1'b0, x[6:0]} : x};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", s, e, g);
    end
  endtask
  // Waits for ev[k] settled after an edge, then lets the taking edge pass
  task automatic wt(input int k);
    int n;
    n = 0;
    #1;
    while (ev[k] !== 1'b1) begin
      @(posedge i_clock);
      #1;
      n++;
      if (n > 3000) begin
        chk("wait", 32'h1, 32'h0);
        report_and_stop();
      end
    end
    @(posedge i_clock);
  endtask
  task automatic hw();
    int n;
    n = 0;
    do begin
      @(posedge i_clock);
      n++;
      if (n > 20) begin
        chk("hready", 32'h1, 32'h0);
        report_and_stop();
      end
    end while (hready !== 1'b1);
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hw();
    htrans <= 2'h0;
    hwdata <= d;
    hw();
    r = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(a, 1'b0, 32'h0);
    chk($sformatf("reg %h", a), e & m, r & m);
  endtask
  task automatic setup(input logic [31:0] m, input logic [5:0] g, input logic [31:0] c);
    ko <= c[1];
    bus(8'h04, 1'b1, 32'h0);
    bus(8'h00, 1'b1, m);
    bus(8'h04, 1'b1, c);
    fmt <= g;
  endtask
  task automatic snd(input logic [7:0] x);
    td <= x;
    tv <= 1'b1;
    wt(5);
    tv <= 1'b0;
  endtask
  initial begin
    repeat (5) @(posedge i_clock);
    i_rst_n <= 1'b1;
    @(posedge i_clock);
    rd(8'h08, 32'h84, 32'hFF);
    bus(8'h14, 1'b1, 32'h3);
    for (int k = 0; k < 6; k++) begin
      v = rnd();
      f = (k == 0) ? 6'h0 : v[5:0];
      setup({25'h0, f[5:1], 2'h0}, f, 32'hF4 | {30'h0, v[7], v[6] & !v[7]});
      bus(8'h0C, 1'b1, {24'h0, v[15:8]});
      bus(8'h08, 1'b1, {24'h0, 7'h3C, f[0]});
      wn = 0;
      do begin
        bus(8'h08, 1'b0, 32'h0);
        wn++;
      end while (r[7] !== 1'b1 && wn < 200);
      chk("tx load", 32'h1, {31'h0, r[7]});
      if (wn >= 200) report_and_stop();
      bus(8'h0C, 1'b1, {24'h0, v[23:16]});
      bus(8'h08, 1'b1, {24'h0, 7'h3C, f[0]});
      wt(0);
      chk("remote data", ch7(v[15:8], f), {24'h0, rdat});
      chk("remote errors", 32'h0, {30'h0, rerr});
      wt(0);
      chk("remote data", ch7(v[23:16], f), {24'h0, rdat});
      wt(3);
      rd(8'h08, 32'h84, 32'h84);
      chk("tx irq", 32'h1, {31'h0, ev[4]});
      snd(v[31:24]);
      wt(2);
      rd(8'h10, ch7(v[31:24], f), 32'hFF);
      rd(8'h08, {24'h0, 6'h31, f[0] & f[1], 1'b0}, f[1] ? 32'hFE : 32'hFC);
      bus(8'h08, 1'b1, 32'h80);
      $display("format %h done", f);
    end
    setup(32'h0, 6'h0, 32'h70);
    snd(8'h5A);
    wt(2);
    snd(8'hA5);
    wt(1);
    rd(8'h10, 32'h5A, 32'hFF);
    rd(8'h08, 32'hE4, 32'hFC);
    bus(8'h04, 1'b1, 32'h60);
    rd(8'h08, 32'hE4, 32'hFC);
    rd(8'h10, 32'h5A, 32'hFF);
    $display("overrun done");
    bus(8'h08, 1'b1, 32'h80);
    setup(32'h20, 6'h18, 32'h70);
    snd(8'h3C);
    wt(1);
    rd(8'h08, 32'h8C, 32'hFC);
    rd(8'h10, 32'h5A, 32'hFF);
    bus(8'h08, 1'b1, 32'h80);
    setup(32'h40, 6'h0, 32'h70);
    snd(8'h35);
    wt(1);
    rd(8'h08, 32'h94, 32'hFC);
    snd(8'h11);
    snd(8'h11);
    snd(8'h11);
    rd(8'h10, 32'h35, 32'hFF);
    $display("receive errors done");
    bus(8'h04, 1'b1, 32'h23);
    bus(8'h08, 1'b1, 32'h78);
    rd(8'h08, 32'h0, 32'h80);
    bus(8'h04, 1'b1, 32'h0);
    rd(8'h08, 32'h80, 32'h80);
    $display("disable done");
    report_and_stop();
  end
endmodule
`default_nettype wire
